// >>> verilog/aptls_top.sv
// burst detection, channel selection and primary sync, with the line timer
`timescale 1ns/100ps
module aptls_top #(
  parameter int PRE_EARTH_CYC = aptls_pkg::PRE_EARTH_CYC,
  parameter int GAP_CYC = aptls_pkg::GAP_CYC,
  parameter int HOLDOFF_CYC = aptls_pkg::HOLDOFF_CYC,
  parameter int EARTH_CYC = aptls_pkg::EARTH_CYC,
  parameter int OTHER_CYC = aptls_pkg::OTHER_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // receiver side
  input wire logic toneTick,
  input wire logic videoBit,
  input wire logic [aptls_pkg::WORD_W-1:0] adcData,
  // operator controls
  input wire logic selIr,
  input wire logic corrEn,
  input wire logic corrPulse,
  // sync and sampling strobes
  output logic syncOut,
  output logic secSyncOut,
  output logic adcConvert,
  output logic xferStrobe,
  output logic acquiring,
  // display side
  output logic dumpStrobe,
  output logic [aptls_pkg::WORD_W-1:0] videoOut,
  output logic videoValid
);
  localparam int CW = aptls_pkg::CNT_W;
  localparam logic [CW-1:0] PRE_LAST = CW'(PRE_EARTH_CYC - 1);
  localparam logic [CW-1:0] GAP_LAST = CW'(GAP_CYC - 1);
  localparam logic [CW-1:0] HOLD_LAST = CW'(HOLDOFF_CYC - 1);
  localparam logic [CW-1:0] SYNC_LAST = CW'(aptls_pkg::SYNC_CYC - 1);

  typedef struct packed {
    aptls_pkg::aptls_sync_state_t state;
    logic [2:0] toneCnt;
    logic [CW-1:0] gapCnt;
    logic [CW-1:0] tmr;
    logic primSync;
    logic [aptls_pkg::WORD_W-1:0] adcWord;
    logic syncOut;
    logic secSyncOut;
    logic adcConvert;
    logic xferStrobe;
    logic acquiring;
    logic dumpStrobe;
    logic [aptls_pkg::WORD_W-1:0] videoOut;
    logic videoValid;
  } aptls_top_regs_t;

  aptls_top_regs_t r;
  aptls_top_regs_t n;
  logic chanMatch;

  aptls_timer_if tif ();

  aptls_line_timer #(
    .EARTH_CYC(EARTH_CYC),
    .OTHER_CYC(OTHER_CYC)
  ) u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .tif(tif)
  );

  assign tif.primSync = r.primSync;
  assign tif.corrEn = corrEn;
  assign tif.corrPulse = corrPulse;
  assign tif.adcWord = r.adcWord;

  // ***************************************************************
  // burst hunt, pre-earth examination and sync pulse
  // ***************************************************************
  always_comb begin
    n = r;
    n.primSync = 1'b0;
    // switch passes the level for infrared, inverted for visible
    chanMatch = selIr ? videoBit : ~videoBit;
    unique case (r.state)
      aptls_pkg::SY_HUNT: begin
        if (toneTick) begin
          n.gapCnt = '0;
          if (r.toneCnt == aptls_pkg::BURST_TRIGGER - 3'h1) begin
            n.toneCnt = '0;
            n.state = aptls_pkg::SY_PRE;
            n.tmr = '0;
          end else begin
            n.toneCnt = r.toneCnt + 3'h1;
          end
        end else if (r.toneCnt != 3'h0) begin
          // stray tone cycles separated by GAP_CYC idle cycles never accumulate into a false burst
          if (r.gapCnt == GAP_LAST) begin
            n.toneCnt = '0;
            n.gapCnt = '0;
          end else begin
            n.gapCnt = r.gapCnt + 1'b1;
          end
        end
      end
      aptls_pkg::SY_PRE: begin
        n.tmr = r.tmr + 1'b1;
        if (r.tmr == PRE_LAST) begin
          n.tmr = '0;
          if (chanMatch) begin
            n.state = aptls_pkg::SY_PULSE;
            n.primSync = 1'b1;
          end else begin
            n.state = aptls_pkg::SY_HUNT;
          end
        end
      end
      aptls_pkg::SY_PULSE: begin
        n.tmr = r.tmr + 1'b1;
        if (r.tmr == SYNC_LAST) begin
          n.state = aptls_pkg::SY_HOLD;
          n.tmr = '0;
        end
      end
      aptls_pkg::SY_HOLD: begin
        // holdoff spans the other channel's burst, so only ours retriggers
        n.toneCnt = '0;
        n.gapCnt = '0;
        n.tmr = r.tmr + 1'b1;
        if (r.tmr == HOLD_LAST) begin
          n.state = aptls_pkg::SY_HUNT;
          n.tmr = '0;
        end
      end
      default: begin
        n.state = aptls_pkg::SY_HUNT;
      end
    endcase
    // ***************************************************************
    // output registers
    // ***************************************************************
    n.syncOut = (n.state == aptls_pkg::SY_PULSE);
    n.adcWord = adcData;
    n.secSyncOut = tif.secSync;
    n.adcConvert = tif.loadTick;
    n.xferStrobe = tif.xferTick;
    n.acquiring = tif.acquiring;
    n.dumpStrobe = tif.dumpTick;
    n.videoValid = tif.dumpValid;
    if (tif.dumpValid) begin
      n.videoOut = tif.dumpWord;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r <= '{state: aptls_pkg::SY_HUNT, default: '0};
    end else begin
      r <= n;
    end
  end

  assign syncOut = r.syncOut;
  assign secSyncOut = r.secSyncOut;
  assign adcConvert = r.adcConvert;
  assign xferStrobe = r.xferStrobe;
  assign acquiring = r.acquiring;
  assign dumpStrobe = r.dumpStrobe;
  assign videoOut = r.videoOut;
  assign videoValid = r.videoValid;
endmodule

// >>> verilog/aptls_pkg.sv
// constants, state codes and timing counts for the line sync and rescan core
package aptls_pkg;

  // ***************************************************************
  // clock and counter widths
  // ***************************************************************
  localparam int CLK_MHZ = 25;
  localparam int CNT_W = 25;

  // ***************************************************************
  // times in microseconds and their cycle counts
  // ***************************************************************
  localparam int SYNC_US = 40;
  localparam int SYNC_CYC = SYNC_US * CLK_MHZ;
  localparam int PRE_EARTH_US = 24450;
  localparam int PRE_EARTH_CYC = PRE_EARTH_US * CLK_MHZ;
  localparam int GAP_US = 4500;
  localparam int GAP_CYC = GAP_US * CLK_MHZ;
  localparam int HOLDOFF_US = 1100000;
  localparam int HOLDOFF_CYC = HOLDOFF_US * CLK_MHZ;
  localparam int EARTH_US = 377780;
  localparam int EARTH_CYC = EARTH_US * CLK_MHZ;
  localparam int OTHER_US = 199440;
  localparam int OTHER_CYC = OTHER_US * CLK_MHZ;

  // ***************************************************************
  // burst detection and line memory
  // ***************************************************************
  localparam logic [2:0] BURST_TRIGGER = 3'h4;
  localparam int WORD_W = 8;
  localparam int ADDR_W = 10;
  localparam int LINE_WORDS = 1024;
  localparam int DUMP_DIV = 2048;
  localparam int DUMP_W = 11;
  localparam int XFER_LAG = 3;

  // ***************************************************************
  // state codes
  // ***************************************************************
  typedef enum logic [3:0] {
    SY_HUNT = 4'h1,
    SY_PRE = 4'h2,
    SY_PULSE = 4'h4,
    SY_HOLD = 4'h8
  } aptls_sync_state_t;

  typedef enum logic [2:0] {
    TM_IDLE = 3'h1,
    TM_ACQ = 3'h2,
    TM_SKIP = 3'h4
  } aptls_tmr_state_t;

endpackage

// >>> verilog/aptls_timer_if.sv
// signals between the sync controller and the line timer
`timescale 1ns/100ps
interface aptls_timer_if;
  logic primSync;
  logic corrEn;
  logic corrPulse;
  logic [aptls_pkg::WORD_W-1:0] adcWord;
  logic secSync;
  logic loadTick;
  logic xferTick;
  logic dumpTick;
  logic acquiring;
  logic [aptls_pkg::WORD_W-1:0] dumpWord;
  logic dumpValid;

  modport ctl (
    output primSync, corrEn, corrPulse, adcWord,
    input secSync, loadTick, xferTick, dumpTick, acquiring, dumpWord, dumpValid
  );
  modport tmr (
    input primSync, corrEn, corrPulse, adcWord,
    output secSync, loadTick, xferTick, dumpTick, acquiring, dumpWord, dumpValid
  );
endinterface

// >>> verilog/aptls_line_timer.sv
// line timer: earth window, sample pacing, line memory and readout
`timescale 1ns/100ps
module aptls_line_timer #(
  parameter int EARTH_CYC = aptls_pkg::EARTH_CYC,
  parameter int OTHER_CYC = aptls_pkg::OTHER_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // controller side
  aptls_timer_if.tmr tif
);
  localparam int LOAD_RAW = EARTH_CYC / aptls_pkg::LINE_WORDS;
  localparam int LOAD_DIV = (LOAD_RAW < 1) ? 1 : LOAD_RAW;
  localparam int AW = aptls_pkg::ADDR_W;
  localparam int CW = aptls_pkg::CNT_W;
  localparam logic [CW-1:0] EARTH_LAST = CW'(EARTH_CYC - 1);
  localparam logic [CW-1:0] OTHER_LAST = CW'(OTHER_CYC - 1);
  localparam logic [CW-1:0] LOAD_LAST = CW'(LOAD_DIV - 1);
  localparam logic [aptls_pkg::DUMP_W-1:0] DUMP_LAST =
    aptls_pkg::DUMP_W'(aptls_pkg::DUMP_DIV - 1);
  localparam logic [AW-1:0] ADDR_LAST = AW'(aptls_pkg::LINE_WORDS - 1);

  typedef struct packed {
    aptls_pkg::aptls_tmr_state_t state;
    logic [CW-1:0] tmr;
    logic [CW-1:0] loadCnt;
    logic [aptls_pkg::DUMP_W-1:0] dumpCnt;
    logic [aptls_pkg::XFER_LAG-1:0] lag;
    logic [AW-1:0] wrAddr;
    logic wrFull;
    logic [AW-1:0] rdAddr;
    logic [AW-1:0] lastAddr;
    logic haveLine;
    logic secSync;
    logic loadTick;
    logic dumpTick;
    logic dumpValid;
  } aptls_tmr_regs_t;

  aptls_tmr_regs_t r;
  aptls_tmr_regs_t n;
  logic [aptls_pkg::WORD_W-1:0] lineMem [aptls_pkg::LINE_WORDS];
  logic [aptls_pkg::WORD_W-1:0] rdWord;
  logic memWe;
  logic rdEn;
  logic paceTick;

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    n = r;
    n.secSync = 1'b0;
    n.loadTick = 1'b0;
    n.dumpTick = 1'b0;
    paceTick = 1'b0;
    // conversion settles while the tick walks down the lag line
    n.lag = {r.lag[aptls_pkg::XFER_LAG-2:0], r.loadTick};
    memWe = r.lag[aptls_pkg::XFER_LAG-1] & ~r.wrFull;
    if (memWe) begin
      // end of line follows the last write, even one still in the lag line
      n.lastAddr = r.wrAddr;
      if (r.wrAddr == ADDR_LAST) begin
        n.wrFull = 1'b1;
      end else begin
        n.wrAddr = r.wrAddr + 1'b1;
      end
    end
    // constant-rate dump divider, never retimed by the line
    if (r.dumpCnt == DUMP_LAST) begin
      n.dumpCnt = '0;
      n.dumpTick = 1'b1;
    end else begin
      n.dumpCnt = r.dumpCnt + 1'b1;
    end
    rdEn = r.dumpTick & r.haveLine & (r.state != aptls_pkg::TM_ACQ);
    n.dumpValid = rdEn;
    if (rdEn) begin
      n.rdAddr = (r.rdAddr == r.lastAddr) ? '0 : r.rdAddr + 1'b1;
    end
    unique case (r.state)
      aptls_pkg::TM_IDLE: begin
        // last line stays and keeps dumping until a new sync arrives
        if (tif.primSync) begin
          n.state = aptls_pkg::TM_ACQ;
          n.secSync = 1'b1;
          n.tmr = '0;
          n.loadCnt = '0;
          n.wrAddr = '0;
          n.wrFull = 1'b0;
          n.haveLine = 1'b0;
        end
      end
      aptls_pkg::TM_ACQ: begin
        n.tmr = r.tmr + 1'b1;
        n.loadCnt = (r.loadCnt == LOAD_LAST) ? '0 : r.loadCnt + 1'b1;
        // corrected pulses give equal ground distance per sample
        // divider's first tick on window cycle 0, so all words fit before the window closes
        paceTick = tif.corrEn ? tif.corrPulse : (r.loadCnt == '0);
        n.loadTick = paceTick & ~r.wrFull;
        if (r.tmr == EARTH_LAST) begin
          n.state = aptls_pkg::TM_SKIP;
          n.tmr = '0;
          n.loadTick = 1'b0;
          n.haveLine = 1'b1;
          n.rdAddr = '0;
        end
      end
      aptls_pkg::TM_SKIP: begin
        n.tmr = r.tmr + 1'b1;
        if (r.tmr == OTHER_LAST) begin
          n.state = aptls_pkg::TM_IDLE;
          n.tmr = '0;
        end
      end
      default: begin
        n.state = aptls_pkg::TM_IDLE;
      end
    endcase
  end

  // ***************************************************************
  // registers and line memory
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r <= '{state: aptls_pkg::TM_IDLE, default: '0};
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge clk) begin
    if (memWe) begin
      lineMem[r.wrAddr] <= tif.adcWord;
    end
    if (rdEn) begin
      rdWord <= lineMem[r.rdAddr];
    end
  end

  assign tif.secSync = r.secSync;
  assign tif.loadTick = r.loadTick;
  assign tif.xferTick = memWe;
  assign tif.dumpTick = r.dumpTick;
  assign tif.acquiring = (r.state == aptls_pkg::TM_ACQ);
  assign tif.dumpWord = rdWord;
  assign tif.dumpValid = r.dumpValid;
endmodule

// >>> sim/aptls_top_assertions.sv
// concurrent checks on the ports of the line sync and rescan core
`timescale 1ns/100ps
module aptls_top_assertions #(
  parameter int EARTH_CYC = aptls_pkg::EARTH_CYC,
  parameter int HOLDOFF_CYC = aptls_pkg::HOLDOFF_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // controls
  input wire logic corrEn,
  // strobes
  input wire logic syncOut,
  input wire logic secSyncOut,
  input wire logic adcConvert,
  input wire logic xferStrobe,
  input wire logic acquiring,
  // display side
  input wire logic dumpStrobe,
  input wire logic [aptls_pkg::WORD_W-1:0] videoOut,
  input wire logic videoValid
);
  // ****
  // run lengths of levels and gaps between strobes
  // ****
  int syncLen_r;
  int acqLen_r;
  int dumpGap_r;
  int sinceSync_r;
  logic dumpSeen_r;
  logic syncSeen_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      syncLen_r <= 0;
      acqLen_r <= 0;
      dumpGap_r <= 0;
      sinceSync_r <= 0;
      dumpSeen_r <= 1'b0;
      syncSeen_r <= 1'b0;
    end else begin
      syncLen_r <= syncOut ? syncLen_r + 1 : 0;
      acqLen_r <= acquiring ? acqLen_r + 1 : 0;
      dumpGap_r <= dumpStrobe ? 0 : dumpGap_r + 1;
      dumpSeen_r <= dumpSeen_r | dumpStrobe;
      sinceSync_r <= (syncOut && syncLen_r == 0) ? 1 : sinceSync_r + 1;
      syncSeen_r <= syncSeen_r | syncOut;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ****
  // assertions
  // ****
  AST_SYNC_WIDTH: assert property ($fell(syncOut) |-> syncLen_r == aptls_pkg::SYNC_CYC)
    else $error("primary sync width wrong");
  AST_SEC_AFTER_SYNC: assert property ($rose(syncOut) |-> ##2 secSyncOut && acquiring)
    else $error("secondary sync missing after primary sync");
  AST_SEC_SINGLE: assert property (secSyncOut |-> $rose(acquiring) ##1 !secSyncOut)
    else $error("secondary sync not a single pulse at window start");
  AST_ACQ_LEN: assert property ($fell(acquiring) |-> acqLen_r == EARTH_CYC)
    else $error("earth window length wrong");
  AST_XFER_AFTER_LOAD: assert property (adcConvert |-> ##3 xferStrobe)
    else $error("transfer strobe not three cycles after load");
  AST_DUMP_PERIOD: assert property (dumpStrobe && dumpSeen_r |-> dumpGap_r == 2047)
    else $error("dump tick period wrong");
  AST_VALID_AFTER_DUMP: assert property (videoValid |-> $past(dumpStrobe))
    else $error("video word without dump tick");
  AST_NO_READ_ACQ: assert property (acquiring && $past(acquiring, 2) |-> !videoValid)
    else $error("readout during acquisition");
  AST_HOLD_VIDEO: assert property (!videoValid |-> $stable(videoOut))
    else $error("video word changed without valid");
  AST_SYNC_SPACING: assert property (
    syncOut && syncLen_r == 0 && syncSeen_r |-> sinceSync_r >= 1000 + HOLDOFF_CYC)
    else $error("primary sync inside holdoff");

  // main scenarios reached
  cover property ($rose(syncOut));
  cover property (adcConvert && corrEn);
  cover property (videoValid);
endmodule

bind aptls_top aptls_top_assertions #(.EARTH_CYC(EARTH_CYC), .HOLDOFF_CYC(HOLDOFF_CYC)) chk (
  .clk(clk), .reset_n(reset_n), .corrEn(corrEn), .syncOut(syncOut),
  .secSyncOut(secSyncOut), .adcConvert(adcConvert), .xferStrobe(xferStrobe),
  .acquiring(acquiring), .dumpStrobe(dumpStrobe), .videoOut(videoOut),
  .videoValid(videoValid)
);

// >>> sim/aptls_rx_model.sv
// receiver model: tone bursts, pre-earth level and converter words
`timescale 1ns/100ps
module aptls_rx_model #(
  parameter int TICK_SP = 8
) (
  // clock
  input wire logic clk,
  // bench control
  input wire logic start,
  input wire logic [2:0] nTicks,
  input wire logic irLine,
  // receiver outputs
  output logic toneTick,
  output logic videoBit,
  output logic [aptls_pkg::WORD_W-1:0] adcData
);
  int left;
  int sp;

  initial begin
    toneTick = 1'b0;
    videoBit = 1'b0;
    adcData = 8'h00;
    left = 0;
    sp = 0;
  end

  // level and word stay for the whole line, so the sample taken is known
  always @(posedge clk) begin
    toneTick <= 1'b0;
    if (start) begin
      left <= nTicks;
      sp <= 0;
      videoBit <= irLine;
      adcData <= irLine ? 8'h3c : 8'hc3;
    end else if (left > 0) begin
      if (sp == 0) begin
        toneTick <= 1'b1;
        left <= left - 1;
        sp <= TICK_SP - 1;
      end else begin
        sp <= sp - 1;
      end
    end
  end
endmodule

// >>> sim/apt_line_sync_and_rescan_control_tb.sv
// self-checking bench for the line sync and rescan core
`timescale 1ns/100ps
module apt_line_sync_and_rescan_control_tb;
  typedef struct packed {
    logic sel;
    logic ir;
    logic corr;
    logic [2:0] n;
    logic exp;
  } aptls_row_t;

  // ****
  // rows: channel, line level, correction, ticks, sync expected
  // ****
  aptls_row_t rows [4] = '{
    '{1'b1, 1'b1, 1'b0, 3'h7, 1'b1},
    '{1'b1, 1'b0, 1'b0, 3'h7, 1'b0},
    '{1'b0, 1'b1, 1'b0, 3'h7, 1'b0},
    '{1'b0, 1'b0, 1'b1, 3'h4, 1'b1}
  };

  logic clk, reset_n, selIr, corrEn, corrPulse, start, lineIr, seen;
  logic [2:0] nTicks;
  logic toneTick, videoBit, syncOut, secSyncOut, adcConvert, xferStrobe, acquiring;
  logic dumpStrobe, videoValid;
  logic [aptls_pkg::WORD_W-1:0] adcData, videoOut;
  int n_fail, total_checks, nLoad;

  // short counts keep the run small
  aptls_top #(.PRE_EARTH_CYC(50), .GAP_CYC(20), .HOLDOFF_CYC(200), .EARTH_CYC(2048),
    .OTHER_CYC(100)) uut (
    .clk(clk), .reset_n(reset_n), .toneTick(toneTick), .videoBit(videoBit),
    .adcData(adcData), .selIr(selIr), .corrEn(corrEn), .corrPulse(corrPulse),
    .syncOut(syncOut), .secSyncOut(secSyncOut), .adcConvert(adcConvert),
    .xferStrobe(xferStrobe), .acquiring(acquiring), .dumpStrobe(dumpStrobe),
    .videoOut(videoOut), .videoValid(videoValid)
  );

  aptls_rx_model rx (
    .clk(clk), .start(start), .nTicks(nTicks), .irLine(lineIr),
    .toneTick(toneTick), .videoBit(videoBit), .adcData(adcData)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // correction train runs free, one pulse every 4 cycles
  initial begin
    corrPulse = 1'b0;
    forever begin
      repeat (3) @(posedge clk);
      #1 corrPulse = 1'b1;
      @(posedge clk);
      #1 corrPulse = 1'b0;
    end
  end

  // ****
  // tasks
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic burst(input logic ir, input logic [2:0] n);
    lineIr = ir;
    nTicks = n;
    start = 1'b1;
    tick(1);
    start = 1'b0;
  endtask

  task automatic waitSync(input int n);
    seen = 1'b0;
    repeat (n) if (!seen) begin
      tick(1);
      seen = syncOut;
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    reset_n = 1'b0;
    selIr = 1'b0;
    corrEn = 1'b0;
    start = 1'b0;
    lineIr = 1'b0;
    nTicks = 3'h0;
    n_fail = 0;
    total_checks = 0;
    tick(16);
    check("reset outputs", 0, {syncOut, secSyncOut, adcConvert, xferStrobe, acquiring,
      dumpStrobe, videoValid, videoOut});
    reset_n = 1'b1;
    $display("reset test done");
    foreach (rows[i]) begin
      selIr = rows[i].sel;
      corrEn = rows[i].corr;
      burst(rows[i].ir, rows[i].n);
      waitSync(200);
      check("syncOut", rows[i].exp, seen);
      if (seen) begin
        nLoad = 0;
        repeat (3000) begin
          tick(1);
          nLoad += adcConvert;
        end
        check("samples", rows[i].corr ? 512 : 1024, nLoad);
      end
      $display("row %0d done", i);
    end
    // split burst: without the gap clear, 3 + 2 ticks would fire
    corrEn = 1'b0;
    burst(1'b0, 3'h3);
    tick(60);
    burst(1'b0, 3'h2);
    waitSync(200);
    check("gap sync", 0, seen);
    $display("gap test done");
    seen = 1'b0;
    repeat (2100) if (!seen) begin
      tick(1);
      seen = videoValid;
    end
    if (!seen) begin
      n_fail++;
      test_done();
    end else begin
      check("videoOut", 8'hc3, videoOut);
    end
    $display("readout test done");
    test_done();
  end
endmodule
